// ==== frt_control.sv ====
// Control and status logic for the fixed reference and temperature sensor.
// Assumes a synchronous register port and a converter reporting starts.
`timescale 1ns/1ps
`default_nettype none
`include "frt_defs.svh"

module frt_control
  import frt_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `FRT_SETTLE_CYC,
  parameter int unsigned TEMP_WAIT_CYC = `FRT_TEMP_WAIT_US * `FRT_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ldo_variant,
  input wire logic conv_start,
  output var frt_analog_t analog_ctrl,
  output logic [3:0] conv_channel,
  output logic temp_routed,
  output logic temp_settled,
  output logic irq
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  wire logic srst_n = rst_sync_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic sel_ctrl = reg_addr == `FRT_OFS_CTRL;
  wire logic sel_stat = reg_addr == `FRT_OFS_IRQ_STAT;
  wire logic sel_mask = reg_addr == `FRT_OFS_IRQ_MASK;
  wire logic sel_chan = reg_addr == `FRT_OFS_CHAN;
  wire logic wr_ctrl = clk_en && reg_wr && sel_ctrl;
  wire logic wr_stat = clk_en && reg_wr && sel_stat;
  wire logic wr_mask = clk_en && reg_wr && sel_mask;
  wire logic wr_chan = clk_en && reg_wr && sel_chan;

  // ****************************************************************
  // Control register
  // ****************************************************************
  frt_ctrl_t ctrl_ff;
  frt_ctrl_t nxt_ctrl;
  logic ready_int;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl.ref_enable = reg_wdata[`FRT_BIT_EN];
      nxt_ctrl.temp_sense_enable = reg_wdata[`FRT_BIT_TEMP_SENSE_ENABLE];
      nxt_ctrl.temp_range_select = reg_wdata[`FRT_BIT_TEMP_RANGE_SELECT];
      nxt_ctrl.cmp_dac_ref_gain = frt_gain_t'(reg_wdata[3:2]);
      nxt_ctrl.converter_ref_gain = frt_gain_t'(reg_wdata[1:0]);
    end
    nxt_ctrl.ref_ready = ready_int;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= frt_ctrl_t'(`FRT_CTRL_RST);
    end else if (!srst_n) begin
      ctrl_ff <= frt_ctrl_t'(`FRT_CTRL_RST);
    end else if (clk_en) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ****************************************************************
  // Settling sequence
  // ****************************************************************
  frt_state_t state_ff;
  frt_state_t nxt_state;
  logic [15:0] settle_cnt_ff;
  logic [15:0] nxt_settle_cnt;
  wire logic en_now = wr_ctrl ? reg_wdata[`FRT_BIT_EN] : ctrl_ff.ref_enable;
  wire logic en_rise = en_now && !ctrl_ff.ref_enable;
  wire logic settle_done = settle_cnt_ff >= 16'(SETTLE_CYC - 1);

  always_comb begin
    nxt_state = state_ff;
    nxt_settle_cnt = settle_cnt_ff;
    unique case (state_ff)
      FRT_ST_OFF: begin
        nxt_settle_cnt = 16'h0000;
        if (en_now) begin
          nxt_state = FRT_ST_SETTLE;
        end
      end
      FRT_ST_SETTLE: begin
        nxt_settle_cnt = settle_cnt_ff + 16'h0001;
        if (settle_done) begin
          nxt_state = FRT_ST_READY;
        end
      end
      FRT_ST_READY: begin
        nxt_settle_cnt = 16'h0000;
      end
      default: begin
        nxt_state = FRT_ST_OFF;
        nxt_settle_cnt = 16'h0000;
      end
    endcase
    if (!en_now) begin
      nxt_state = FRT_ST_OFF;
      nxt_settle_cnt = 16'h0000;
    end else if (en_rise) begin
      nxt_state = FRT_ST_SETTLE;
      nxt_settle_cnt = 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= FRT_ST_OFF;
      settle_cnt_ff <= 16'h0000;
    end else if (!srst_n) begin
      state_ff <= FRT_ST_OFF;
      settle_cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      settle_cnt_ff <= nxt_settle_cnt;
    end
  end

  // Ready clears at once when the enable drops, unless ldo_variant holds it set
  assign ready_int = ldo_variant
    || (nxt_state == FRT_ST_READY && en_now);

  // ****************************************************************
  // Converter channel and temperature guard
  // ****************************************************************
  logic [3:0] chan_ff;
  logic [15:0] guard_cnt_ff;
  logic [15:0] nxt_guard_cnt;
  logic settled_ff;
  wire logic routed_now = chan_ff == `FRT_TEMP_CHAN;
  wire logic route_start = wr_chan && reg_wdata[3:0] == `FRT_TEMP_CHAN
    && !routed_now;
  wire logic leave_temp = wr_chan && reg_wdata[3:0] != `FRT_TEMP_CHAN;
  wire logic guard_restart = route_start || (clk_en && conv_start
    && routed_now);
  wire logic guard_hit = guard_cnt_ff == 16'(TEMP_WAIT_CYC - 1);
  wire logic temp_evt = clk_en && routed_now && !settled_ff
    && guard_hit && !guard_restart;

  always_comb begin
    nxt_guard_cnt = guard_cnt_ff;
    if (guard_restart) begin
      nxt_guard_cnt = 16'h0000;
    end else if (routed_now && !settled_ff && !guard_hit) begin
      nxt_guard_cnt = guard_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_ff <= `FRT_CHAN_RST;
      guard_cnt_ff <= 16'h0000;
      settled_ff <= 1'b0;
    end else if (!srst_n) begin
      chan_ff <= `FRT_CHAN_RST;
      guard_cnt_ff <= 16'h0000;
      settled_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_chan) begin
        chan_ff <= reg_wdata[3:0];
      end
      guard_cnt_ff <= nxt_guard_cnt;
      if (guard_restart || leave_temp) begin
        settled_ff <= 1'b0;
      end else if (temp_evt) begin
        settled_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [`FRT_IRQ_BITS-1:0] stat_ff;
  logic [`FRT_IRQ_BITS-1:0] mask_ff;
  logic [`FRT_IRQ_BITS-1:0] evt;
  logic [`FRT_IRQ_BITS-1:0] nxt_stat;
  wire logic rdy_evt = clk_en && ready_int && !ctrl_ff.ref_ready;

  always_comb begin
    evt = '0;
    evt[`FRT_IRQ_RDY] = rdy_evt;
    evt[`FRT_IRQ_TEMP] = temp_evt;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FRT_IRQ_BITS; gi++) begin : g_stat
      // A new event beats a clear in the same cycle
      assign nxt_stat[gi] = evt[gi]
        || (stat_ff[gi] && !(wr_stat && reg_wdata[gi]));
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= '0;
      mask_ff <= '0;
    end else if (!srst_n) begin
      stat_ff <= '0;
      mask_ff <= '0;
    end else if (clk_en) begin
      stat_ff <= nxt_stat;
      if (wr_mask) begin
        mask_ff <= reg_wdata[`FRT_IRQ_BITS-1:0];
      end
    end
  end

  assign irq = |(stat_ff & mask_ff);

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [7:0] rd_mux;
  logic [7:0] rdata_ff;

  always_comb begin
    rd_mux = 8'h00;
    if (sel_ctrl) begin
      rd_mux = ctrl_ff;
    end else if (sel_stat) begin
      rd_mux[`FRT_IRQ_BITS-1:0] = stat_ff;
    end else if (sel_mask) begin
      rd_mux[`FRT_IRQ_BITS-1:0] = mask_ff;
    end else if (sel_chan) begin
      rd_mux = {3'h0, settled_ff, chan_ff};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (!srst_n) begin
      rdata_ff <= 8'h00;
    end else if (clk_en) begin
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

  // ****************************************************************
  // Analog controls
  // ****************************************************************
  always_comb begin
    analog_ctrl.ref_on = ctrl_ff.ref_enable;
    analog_ctrl.conv_gain = ctrl_ff.converter_ref_gain;
    analog_ctrl.conv_path_on = ctrl_ff.ref_enable
      && ctrl_ff.converter_ref_gain != FRT_GAIN_OFF;
    analog_ctrl.cmp_gain = ctrl_ff.cmp_dac_ref_gain;
    analog_ctrl.cmp_path_on = ctrl_ff.ref_enable
      && ctrl_ff.cmp_dac_ref_gain != FRT_GAIN_OFF;
    analog_ctrl.temp_on = ctrl_ff.temp_sense_enable;
    analog_ctrl.temp_high = ctrl_ff.temp_range_select;
  end

  assign conv_channel = chan_ff;
  assign temp_routed = routed_now;
  assign temp_settled = settled_ff;

endmodule : frt_control
`default_nettype wire

// ==== frt_defs.svh ====
// Constants for the fixed reference and temperature control block.
// Assumes a 250 MHz core clock and an 8-bit register port.
//
// What this block does
// - Control bit 7 turns reference on/off
// - Ready set only after settling wait
// - Ready reads zero unless enabled and settled
// - Regulator variant: ready always reads one
// - Two independent gain stages, 1x/2x/4x each
// - Bits 3-2: off, 1x, 2x, 4x
// - Bits 1-0: same mapping for converter
// - Bit 5 powers the temperature circuit
// - Bit 4 selects high or low range
// - One converter channel reserved for temperature
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FRT_OFS_CTRL 4'h0
`define FRT_OFS_IRQ_STAT 4'h1
`define FRT_OFS_IRQ_MASK 4'h2
`define FRT_OFS_CHAN 4'h3

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define FRT_BIT_EN 7
`define FRT_BIT_RDY 6
`define FRT_BIT_TEMP_SENSE_ENABLE 5
`define FRT_BIT_TEMP_RANGE_SELECT 4
`define FRT_CTRL_RST 8'h00
`define FRT_IRQ_RDY 0
`define FRT_IRQ_TEMP 1
`define FRT_IRQ_BITS 2
`define FRT_CHAN_RST 4'h0
`define FRT_TEMP_CHAN 4'hd

// ****************************************************************
// Timing
// ****************************************************************
`define FRT_CLK_MHZ 250
`define FRT_SETTLE_CYC 1000
`define FRT_TEMP_WAIT_US 200

`endif

// ==== frt_pkg.sv ====
// Types for the fixed reference and temperature control block.
// Assumes frt_defs.svh supplies the numeric constants.
package frt_pkg;

  typedef enum logic [1:0] {
    FRT_GAIN_OFF = 2'b00,
    FRT_GAIN_X1 = 2'b01,
    FRT_GAIN_X2 = 2'b10,
    FRT_GAIN_X4 = 2'b11
  } frt_gain_t;

  typedef enum logic [1:0] {
    FRT_ST_OFF = 2'b00,
    FRT_ST_SETTLE = 2'b01,
    FRT_ST_READY = 2'b10
  } frt_state_t;

  typedef struct packed {
    logic ref_enable;
    logic ref_ready;
    logic temp_sense_enable;
    logic temp_range_select;
    frt_gain_t cmp_dac_ref_gain;
    frt_gain_t converter_ref_gain;
  } frt_ctrl_t;

  typedef struct packed {
    logic ref_on;
    logic conv_path_on;
    frt_gain_t conv_gain;
    logic cmp_path_on;
    frt_gain_t cmp_gain;
    logic temp_on;
    logic temp_high;
  } frt_analog_t;

endpackage : frt_pkg

// ==== frt_control_sva.sv ====
// Port checker for frt_control.
// Assumes one clock domain and the register offsets of frt_defs.svh.
`timescale 1ns/1ps
`default_nettype none
module frt_control_sva
  import frt_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 4,
  parameter int unsigned TEMP_WAIT_CYC = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ldo_variant,
  input wire logic conv_start,
  input wire frt_analog_t analog_ctrl,
  input wire logic [3:0] conv_channel,
  input wire logic temp_routed,
  input wire logic temp_settled
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence ctrl_wr;
    clk_en && reg_wr && reg_addr == 4'h0;
  endsequence
  sequence ctrl_rd;
    clk_en && reg_rd && reg_addr == 4'h0;
  endsequence
  sequence chan_wr;
    clk_en && reg_wr && reg_addr == 4'h3;
  endsequence
  sequence route_new;
    chan_wr ##0 (reg_wdata[3:0] == 4'hd && conv_channel != 4'hd);
  endsequence
  a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_ref_follow: assert property (ctrl_wr |=>
    analog_ctrl.ref_on == $past(reg_wdata[7])) else $error("ref enable");
  a_conv_gain: assert property (ctrl_wr |=>
    analog_ctrl.conv_gain == $past(reg_wdata[1:0])
    && analog_ctrl.conv_path_on
      == ($past(reg_wdata[7]) && |$past(reg_wdata[1:0])))
    else $error("converter gain");
  a_cmp_gain: assert property (ctrl_wr |=>
    analog_ctrl.cmp_gain == $past(reg_wdata[3:2])
    && analog_ctrl.cmp_path_on
      == ($past(reg_wdata[7]) && |$past(reg_wdata[3:2])))
    else $error("comparator gain");
  a_ready_off: assert property (ctrl_rd ##0 (!analog_ctrl.ref_on
    && !ldo_variant && !$past(ldo_variant)) |=> !reg_rdata[6])
    else $error("ready while reference off");
  a_ldo_ready: assert property (ctrl_rd ##0 (ldo_variant
    && $past(ldo_variant)) |=> reg_rdata[6])
    else $error("regulator ready");
  a_temp_bits: assert property (ctrl_wr |=>
    {analog_ctrl.temp_on, analog_ctrl.temp_high} == $past(reg_wdata[5:4]))
    else $error("temperature bits");
  a_chan_write: assert property (chan_wr |=>
    conv_channel == $past(reg_wdata[3:0])) else $error("channel");
  a_routed_map: assert property (temp_routed == (conv_channel == 4'hd))
    else $error("routed flag");
  a_route_settle: assert property (route_new |=>
    (!temp_settled) [*6] ##[1:6] temp_settled) else $error("settle wait");
  a_start_restart: assert property (
    clk_en && conv_start && temp_routed |=> !temp_settled)
    else $error("start restart");
  a_leave_clear: assert property (
    chan_wr ##0 reg_wdata[3:0] != 4'hd |=> !temp_settled && !temp_routed)
    else $error("leave channel");
endmodule : frt_control_sva
bind frt_control frt_control_sva #(
  .SETTLE_CYC(SETTLE_CYC),
  .TEMP_WAIT_CYC(TEMP_WAIT_CYC)
) u_sva (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .ldo_variant(ldo_variant),
  .conv_start(conv_start),
  .analog_ctrl(analog_ctrl),
  .conv_channel(conv_channel),
  .temp_routed(temp_routed),
  .temp_settled(temp_settled)
);
`default_nettype wire

// ==== frt_tb.sv ====
// Testbench for frt_control.
// Assumes short settle counts of 4 and 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import frt_pkg::*;
  logic core_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic ldo_variant = 0, conv_start = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  frt_analog_t ac;
  logic [3:0] conv_channel;
  logic temp_routed, temp_settled, irq;
  int fails = 0, cmp_count = 0;
  frt_control #(.SETTLE_CYC(4), .TEMP_WAIT_CYC(8)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ldo_variant(ldo_variant),
    .conv_start(conv_start), .analog_ctrl(ac),
    .conv_channel(conv_channel), .temp_routed(temp_routed),
    .temp_settled(temp_settled), .irq(irq));
  // ****************************************
  // Bus tasks
  // ****************************************
  initial forever #2 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, reg_rdata, e);
  endtask : rd
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #20000;
    fails++;
    test_done();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int a = 0; a < 4; a++) rd(4'(a), 8'h00, "reset value");
    for (int k = 0; k < 16; k++) begin
      wr(4'h0, {2'b00, k[1:0], k[3:0]});
      chk("cmp gain", {6'h00, ac.cmp_gain}, {6'h00, k[3:2]});
      chk("conv gain", {6'h00, ac.conv_gain}, {6'h00, k[1:0]});
      chk("paths", {6'h00, ac.cmp_path_on, ac.conv_path_on},
          8'h00);
      chk("temp", {6'h00, ac.temp_on, ac.temp_high}, {6'h00, k[1:0]});
      rd(4'h0, {2'b00, k[1:0], k[3:0]}, "ctrl");
    end
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h00, "ready read only");
    @(posedge core_clk);
    ldo_variant <= 1'b1;
    rd(4'h0, 8'h40, "ldo ready");
    rd(4'h1, 8'h01, "ldo status");
    @(posedge core_clk);
    ldo_variant <= 1'b0;
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h83);
    rd(4'h0, 8'h83, "settling");
    chk("irq early", {7'h00, irq}, 8'h00);
    chk("ref on", {7'h00, ac.ref_on}, 8'h01);
    chk("paths on", {6'h00, ac.cmp_path_on, ac.conv_path_on}, 8'h01);
    repeat (8) @(posedge core_clk);
    rd(4'h0, 8'hc3, "ready");
    chk("irq ready", {7'h00, irq}, 8'h01);
    rd(4'h1, 8'h01, "status");
    wr(4'h1, 8'h01);
    chk("irq clear", {7'h00, irq}, 8'h00);
    wr(4'h0, 8'h03);
    rd(4'h0, 8'h03, "disabled");
    chk("ref off", {7'h00, ac.ref_on}, 8'h00);
    wr(4'h0, 8'h80);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'h80, "restart");
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h00, "unmapped");
    wr(4'h2, 8'h02);
    wr(4'h3, 8'h0d);
    chk("routed", {7'h00, temp_routed}, 8'h01);
    rd(4'h3, 8'h0d, "chan");
    chk("irq masked", {7'h00, irq}, 8'h00);
    repeat (12) @(posedge core_clk);
    rd(4'h3, 8'h1d, "settled");
    chk("irq temp", {7'h00, irq}, 8'h01);
    rd(4'h1, 8'h03, "status both");
    wr(4'h1, 8'h03);
    chk("irq off", {7'h00, irq}, 8'h00);
    @(posedge core_clk);
    conv_start <= 1'b1;
    @(posedge core_clk);
    conv_start <= 1'b0;
    #1;
    chk("restart wait", {7'h00, temp_settled}, 8'h00);
    repeat (12) @(posedge core_clk);
    chk("wait done", {7'h00, temp_settled}, 8'h01);
    wr(4'h3, 8'h03);
    chk("unrouted", {6'h00, temp_routed, temp_settled}, 8'h00);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(4'h3, 8'h05);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(4'h3, 8'h03, "frozen write");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(4'h0, 8'h00, "ctrl after reset");
    rd(4'h3, 8'h00, "chan after reset");
    test_done();
  end
endmodule : tb
`default_nettype wire
